// ===== hdl/tmrm_params.svh
// Constants of the temperature monitor register bank
`ifndef TMRM_PARAMS_SVH
`define TMRM_PARAMS_SVH

// ==================================================
// Pointer values
`define TMRM_PTR_LOC_HI 8'h00
`define TMRM_PTR_REM_HI 8'h01
`define TMRM_PTR_STATUS 8'h02
`define TMRM_PTR_REM_LO 8'h10
`define TMRM_PTR_LOC_LO 8'h15
`define TMRM_PTR_SOFT_RST 8'hfc
`define TMRM_PTR_MAKER 8'hfe
`define TMRM_PTR_PART 8'hff

// ==================================================
// Read/write slot tables, slot 0 in the low byte
`define TMRM_NSLOT 24
`define TMRM_RD_PTRS {8'h37, 8'h36, 8'h35, 8'h34, 8'h33, 8'h32, 8'h31, 8'h30, 8'h22, 8'h21, 8'h20, 8'h1a, \
  8'h19, 8'h18, 8'h17, 8'h16, 8'h14, 8'h13, 8'h08, 8'h07, 8'h06, 8'h05, 8'h04, 8'h03}
`define TMRM_WR_PTRS {8'h37, 8'h36, 8'h35, 8'h34, 8'h33, 8'h32, 8'h31, 8'h30, 8'h22, 8'h21, 8'h20, 8'h1a, \
  8'h19, 8'h18, 8'h17, 8'h16, 8'h14, 8'h13, 8'h0e, 8'h0d, 8'h0c, 8'h0b, 8'h0a, 8'h09}
`define TMRM_RW_RESET {8'h00, 8'h00, 8'hf0, 8'hff, 8'h00, 8'h00, 8'hf0, 8'hff, 8'h80, 8'h0a, 8'h55, 8'h1c, \
  8'h55, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h55, 8'h00, 8'h55, 8'h08, 8'h00}
`define TMRM_RW_MASK {8'hf0, 8'hff, 8'hf0, 8'hff, 8'hf0, 8'hff, 8'hf0, 8'hff, 8'h8e, 8'hff, 8'hff, 8'h03, \
  8'hff, 8'hff, 8'hf0, 8'hf0, 8'hf0, 8'hf0, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'he4}

// ==================================================
// Slot numbers used by name
`define TMRM_SLOT_SETUP 5'd0
`define TMRM_SLOT_RATE 5'd1
`define TMRM_SLOT_LUH 5'd2
`define TMRM_SLOT_LLH 5'd3
`define TMRM_SLOT_RUH 5'd4
`define TMRM_SLOT_RLH 5'd5
`define TMRM_SLOT_RUL 5'd6
`define TMRM_SLOT_RLL 5'd7
`define TMRM_SLOT_LUL 5'd8
`define TMRM_SLOT_LLL 5'd9
`define TMRM_SLOT_CORR 5'd10
`define TMRM_SLOT_PREC 5'd12
`define TMRM_SLOT_LMIN 5'd16
`define TMRM_SLOT_LMAX 5'd18
`define TMRM_SLOT_RMIN 5'd20
`define TMRM_SLOT_RMAX 5'd22

// ==================================================
// Result layout
`define TMRM_RES_W 12
`define TMRM_FRAC_W 4
`define TMRM_MIN_HI_RST 8'hff
`define TMRM_MIN_LO_RST 8'hf0

`endif

// ===== hdl/tmrm_pkg.sv
// Types of the temperature monitor register bank
package tmrm_pkg;
  `include "tmrm_params.svh"

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WRITE = 2'b01,
    PH_READ = 2'b10
  } tmrm_phase_t;

  typedef struct packed {
    tmrm_phase_t phase;
    logic [1:0] idx;
    logic [7:0] ptr;
    logic [`TMRM_NSLOT-1:0][7:0] rw;
    logic [7:0] rd_data;
    logic rd_valid;
  } tmrm_state_t;

  typedef struct packed {
    logic [`TMRM_RES_W-1:0] loc;
    logic [`TMRM_RES_W-1:0] rem;
    logic [`TMRM_FRAC_W-1:0] shadow;
    logic sh_valid;
    logic sh_remote;
  } tmrm_store_t;
endpackage

// ===== hdl/tmrm_if.sv
// Link between the register bank and its result store
`timescale 1ns/1ps
interface tmrm_if;
  logic cap_loc;
  logic cap_rem;
  logic release_sh;
  logic soft_clear;
  logic loc_done;
  logic rem_done;
  logic [11:0] loc_data;
  logic [11:0] rem_data;
  logic [7:0] loc_hi;
  logic [7:0] loc_lo;
  logic [7:0] rem_hi;
  logic [7:0] rem_lo;
  logic [11:0] loc_now;
  logic [11:0] rem_now;

  modport ctl (output cap_loc, cap_rem, release_sh, soft_clear, loc_done, rem_done, loc_data, rem_data,
    input loc_hi, loc_lo, rem_hi, rem_lo, loc_now, rem_now);
  modport store (input cap_loc, cap_rem, release_sh, soft_clear, loc_done, rem_done, loc_data, rem_data,
    output loc_hi, loc_lo, rem_hi, rem_lo, loc_now, rem_now);
endinterface

// ===== hdl/tmrm_result_store.sv
// Result registers with the low-byte coherence latch
`timescale 1ns/1ps
module tmrm_result_store
  import tmrm_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Bank side
  tmrm_if.store lnk
);
  tmrm_store_t s_reg;
  tmrm_store_t s_next;

  // ==================================================
  // Next state
  always_comb begin
    s_next = s_reg;
    if (lnk.cap_loc) begin
      s_next.shadow = s_reg.loc[3:0];
      s_next.sh_valid = 1'b1;
      s_next.sh_remote = 1'b0;
    end else if (lnk.cap_rem) begin
      s_next.shadow = s_reg.rem[3:0];
      s_next.sh_valid = 1'b1;
      s_next.sh_remote = 1'b1;
    end else if (lnk.release_sh) begin
      s_next.sh_valid = 1'b0;
    end
    if (lnk.loc_done) begin
      s_next.loc = lnk.loc_data;
    end
    if (lnk.rem_done) begin
      s_next.rem = lnk.rem_data;
    end
    if (lnk.soft_clear) begin
      s_next = '0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==================================================
  // Views, fraction in the top nibble
  assign lnk.loc_hi = s_reg.loc[11:4];
  assign lnk.rem_hi = s_reg.rem[11:4];
  assign lnk.loc_lo = {(s_reg.sh_valid && !s_reg.sh_remote) ? s_reg.shadow : s_reg.loc[3:0], 4'h0};
  assign lnk.rem_lo = {(s_reg.sh_valid && s_reg.sh_remote) ? s_reg.shadow : s_reg.rem[3:0], 4'h0};
  assign lnk.loc_now = s_reg.loc;
  assign lnk.rem_now = s_reg.rem;

  // ==================================================
  // Checks
  AST_RES_LOAD: assert property (@(posedge sys_clk) disable iff (reset)
    lnk.loc_done && !lnk.soft_clear |=> lnk.loc_now == $past(lnk.loc_data))
    else $error("local result not loaded");
  AST_COHERENT: assert property (@(posedge sys_clk) disable iff (reset)
    lnk.cap_loc && !lnk.soft_clear ##1 !lnk.release_sh && !lnk.cap_loc && !lnk.cap_rem && !lnk.soft_clear
      |=> lnk.loc_lo == $past(lnk.loc_lo, 1))
    else $error("captured low byte changed");
  AST_RELEASE: assert property (@(posedge sys_clk) disable iff (reset)
    lnk.release_sh && !lnk.cap_loc && !lnk.cap_rem && !lnk.loc_done && !lnk.soft_clear
      |=> lnk.loc_lo == {lnk.loc_now[3:0], 4'h0})
    else $error("low byte still held after other read");
  AST_LOW_ZERO: assert property (@(posedge sys_clk) disable iff (reset)
    lnk.loc_lo[3:0] == 4'h0 && lnk.rem_lo[3:0] == 4'h0)
    else $error("low byte bits 3..0 not zero");
  AST_SOFT_CLEAR: assert property (@(posedge sys_clk) disable iff (reset)
    lnk.soft_clear |=> lnk.loc_now == '0 && lnk.rem_now == '0)
    else $error("results not cleared");
endmodule // tmrm_result_store

// ===== hdl/tmrm_regbank.sv
// Pointer-addressed register bank of the temperature monitor
`timescale 1ns/1ps
module tmrm_regbank
  import tmrm_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
  parameter logic [7:0] PART_CODE = 8'h3c // Arbitrary value
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Byte-level host port
  input wire logic bus_start,
  input wire logic bus_read,
  input wire logic bus_stop,
  input wire logic bus_wr_valid,
  input wire logic [7:0] bus_wr_byte,
  input wire logic bus_rd_req,
  output logic [7:0] bus_rd_byte,
  output logic bus_rd_valid,
  // Converter results
  input wire logic loc_done,
  input wire logic [11:0] loc_data,
  input wire logic rem_done,
  input wire logic [11:0] rem_data,
  input wire logic [7:0] status_flags,
  // Settings for the measurement core
  output logic [7:0] setup_out,
  output logic [7:0] rate_out,
  output logic [7:0] precision_out,
  output logic [7:0] correction_out
);
  localparam logic [`TMRM_NSLOT*8-1:0] RD_PTRS = `TMRM_RD_PTRS;
  localparam logic [`TMRM_NSLOT*8-1:0] WR_PTRS = `TMRM_WR_PTRS;
  localparam logic [`TMRM_NSLOT*8-1:0] RW_RESET = `TMRM_RW_RESET;
  localparam logic [`TMRM_NSLOT*8-1:0] RW_MASK = `TMRM_RW_MASK;

  tmrm_state_t s_reg;
  tmrm_state_t s_next;
  tmrm_if lnk ();

  // ==================================================
  // Decoding helpers
  // Slot lookup in a pointer table; bit 5 flags a hit
  function automatic logic [5:0] find_slot(input logic [`TMRM_NSLOT*8-1:0] tbl, input logic [7:0] p);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < `TMRM_NSLOT; i++) begin
      if (tbl[i*8 +: 8] == p) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

  // Low-byte partner of a limit high-byte slot; bit 5 flags one exists
  function automatic logic [5:0] partner(input logic [4:0] slot);
    case (slot)
      `TMRM_SLOT_LUH: partner = {1'b1, `TMRM_SLOT_LUL};
      `TMRM_SLOT_LLH: partner = {1'b1, `TMRM_SLOT_LLL};
      `TMRM_SLOT_RUH: partner = {1'b1, `TMRM_SLOT_RUL};
      `TMRM_SLOT_RLH: partner = {1'b1, `TMRM_SLOT_RLL};
      default: partner = 6'h00;
    endcase
  endfunction

  function automatic tmrm_state_t reset_state();
    tmrm_state_t r;
    r = '0;
    r.phase = PH_IDLE;
    r.rw = RW_RESET;
    return r;
  endfunction

  // Current-pointer read; the bus only reads these results, and only a software reset write or the reset input clears them
  function automatic logic [7:0] read_byte(input tmrm_state_t st, input logic [7:0] p, input logic second);
    logic [5:0] hit;
    logic [5:0] lo;
    hit = find_slot(RD_PTRS, p);
    lo = partner(hit[4:0]);
    read_byte = 8'h00;
    // second byte of a result or limit pair
    if (second && p == `TMRM_PTR_LOC_HI) begin
      read_byte = lnk.loc_lo;
    end else if (second && p == `TMRM_PTR_REM_HI) begin
      read_byte = lnk.rem_lo;
    end else if (second && hit[5] && lo[5]) begin
      read_byte = st.rw[lo[4:0]];
    end else begin
      case (p)
        `TMRM_PTR_LOC_HI: read_byte = lnk.loc_hi;
        `TMRM_PTR_LOC_LO: read_byte = lnk.loc_lo;
        `TMRM_PTR_REM_HI: read_byte = lnk.rem_hi;
        `TMRM_PTR_REM_LO: read_byte = lnk.rem_lo;
        `TMRM_PTR_STATUS: read_byte = status_flags;
        `TMRM_PTR_MAKER: read_byte = MAKER_CODE;
        `TMRM_PTR_PART: read_byte = PART_CODE;
        default: begin
          // shared pointers resolve through the read table
          if (hit[5]) begin
            read_byte = st.rw[hit[4:0]];
          end
        end
      endcase
    end
  endfunction

  // ==================================================
  // Tracker update from a fresh conversion
  function automatic logic [15:0] track(input logic [15:0] cur, input logic [11:0] val, input logic want_min);
    logic [11:0] held;
    held = {cur[15:8], cur[7:4]};
    track = cur;
    if (want_min ? (val < held) : (val > held)) begin
      track = {val[11:4], val[3:0], 4'h0};
    end
  endfunction

  // ==================================================
  // Next state
  logic rd_fire;
  logic wr_fire;
  logic [5:0] wr_hit;
  logic [5:0] wr_lo;
  logic [7:0] rd_ptr_now;
  logic rd_second;
  logic soft_rst;

  always_comb begin
    rd_fire = bus_rd_req && s_reg.phase == PH_READ;
    wr_fire = bus_wr_valid && s_reg.phase == PH_WRITE;
    wr_hit = find_slot(WR_PTRS, s_reg.ptr);
    wr_lo = partner(wr_hit[4:0]);
    rd_second = s_reg.idx != 2'd0;
    rd_ptr_now = s_reg.ptr;
    soft_rst = 1'b0;
    s_next = s_reg;
    s_next.rd_valid = 1'b0;

    if (loc_done) begin
      {s_next.rw[`TMRM_SLOT_LMIN], s_next.rw[`TMRM_SLOT_LMIN + 5'd1]} =
        track({s_reg.rw[`TMRM_SLOT_LMIN], s_reg.rw[`TMRM_SLOT_LMIN + 5'd1]}, loc_data, 1'b1);
      {s_next.rw[`TMRM_SLOT_LMAX], s_next.rw[`TMRM_SLOT_LMAX + 5'd1]} =
        track({s_reg.rw[`TMRM_SLOT_LMAX], s_reg.rw[`TMRM_SLOT_LMAX + 5'd1]}, loc_data, 1'b0);
    end
    if (rem_done) begin
      {s_next.rw[`TMRM_SLOT_RMIN], s_next.rw[`TMRM_SLOT_RMIN + 5'd1]} =
        track({s_reg.rw[`TMRM_SLOT_RMIN], s_reg.rw[`TMRM_SLOT_RMIN + 5'd1]}, rem_data, 1'b1);
      {s_next.rw[`TMRM_SLOT_RMAX], s_next.rw[`TMRM_SLOT_RMAX + 5'd1]} =
        track({s_reg.rw[`TMRM_SLOT_RMAX], s_reg.rw[`TMRM_SLOT_RMAX + 5'd1]}, rem_data, 1'b0);
    end

    case (s_reg.phase)
      PH_WRITE: begin
        if (wr_fire) begin
          s_next.idx = (s_reg.idx == 2'd3) ? 2'd3 : s_reg.idx + 2'd1;
          if (s_reg.idx == 2'd0) begin
            s_next.ptr = bus_wr_byte;
          end else if (s_reg.idx == 2'd1) begin
            if (s_reg.ptr == `TMRM_PTR_SOFT_RST) begin
              soft_rst = 1'b1;
            end else if (wr_hit[5]) begin
              s_next.rw[wr_hit[4:0]] = (s_reg.rw[wr_hit[4:0]] & ~RW_MASK[wr_hit[4:0]*8 +: 8]) |
                (bus_wr_byte & RW_MASK[wr_hit[4:0]*8 +: 8]);
            end
          end else if (s_reg.idx == 2'd2 && wr_hit[5] && wr_lo[5]) begin
            // Two-byte limit write, high byte first
            s_next.rw[wr_lo[4:0]] = bus_wr_byte & RW_MASK[wr_lo[4:0]*8 +: 8];
          end
        end
      end
      PH_READ: begin
        if (rd_fire) begin
          s_next.idx = (s_reg.idx == 2'd3) ? 2'd3 : s_reg.idx + 2'd1;
          s_next.rd_data = read_byte(s_reg, rd_ptr_now, rd_second);
          s_next.rd_valid = 1'b1;
        end
      end
      PH_IDLE: begin
        s_next.idx = 2'd0;
      end
      default: begin
        s_next.phase = PH_IDLE;
      end
    endcase

    // A new start overrides a missing stop
    if (bus_start) begin
      s_next.phase = bus_read ? PH_READ : PH_WRITE;
      s_next.idx = 2'd0;
    end else if (bus_stop) begin
      s_next.phase = PH_IDLE;
      s_next.idx = 2'd0;
    end

    if (soft_rst) begin
      s_next = reset_state();
      s_next.phase = s_reg.phase;
      s_next.idx = s_next.phase == PH_IDLE ? 2'd0 : 2'd3;
      s_next.ptr = s_reg.ptr;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_reg <= reset_state();
    end else begin
      s_reg <= s_next;
    end
  end

  // ==================================================
  // Result store hookup
  // high-byte read at the pointer latches
  assign lnk.cap_loc = rd_fire && !rd_second && s_reg.ptr == `TMRM_PTR_LOC_HI;
  assign lnk.cap_rem = rd_fire && !rd_second && s_reg.ptr == `TMRM_PTR_REM_HI;
  // every other read, low ones included, ends the hold
  assign lnk.release_sh = rd_fire && !lnk.cap_loc && !lnk.cap_rem;
  assign lnk.soft_clear = soft_rst;
  // results come from the converter only
  assign lnk.loc_done = loc_done;
  assign lnk.rem_done = rem_done;
  assign lnk.loc_data = loc_data;
  assign lnk.rem_data = rem_data;

  tmrm_result_store u_store (
    .sys_clk(sys_clk),
    .reset(reset),
    .lnk(lnk.store)
  );

  // ==================================================
  // Outputs, all from state flops
  assign bus_rd_byte = s_reg.rd_data;
  assign bus_rd_valid = s_reg.rd_valid;
  assign setup_out = s_reg.rw[`TMRM_SLOT_SETUP];
  assign rate_out = s_reg.rw[`TMRM_SLOT_RATE];
  assign precision_out = s_reg.rw[`TMRM_SLOT_PREC];
  assign correction_out = s_reg.rw[`TMRM_SLOT_CORR];

  // ==================================================
  // Checks
  sequence s_cmd_byte;
    bus_wr_valid && s_reg.phase == PH_WRITE && s_reg.idx == 2'd0 && !bus_start && !bus_stop;
  endsequence

  sequence s_soft_write;
    bus_wr_valid && s_reg.phase == PH_WRITE && s_reg.idx == 2'd1 && s_reg.ptr == `TMRM_PTR_SOFT_RST;
  endsequence

  sequence s_pair_local;
    bus_rd_req && s_reg.phase == PH_READ && s_reg.idx == 2'd0 && s_reg.ptr == `TMRM_PTR_LOC_HI
      && !bus_start && !bus_stop && !lnk.soft_clear;
  endsequence

  AST_PTR_LOAD: assert property (@(posedge sys_clk) disable iff (reset)
    s_cmd_byte |=> s_reg.ptr == $past(bus_wr_byte))
    else $error("pointer not loaded by command byte");
  AST_RD_ANSWER: assert property (@(posedge sys_clk) disable iff (reset)
    bus_rd_req && s_reg.phase == PH_READ |=> bus_rd_valid ##1 !bus_rd_valid || $past(bus_rd_req))
    else $error("read answer missing");
  AST_PAIR_LOW: assert property (@(posedge sys_clk) disable iff (reset)
    s_pair_local ##1 (bus_rd_req && !bus_start && !bus_stop)
      |=> bus_rd_byte == {$past(lnk.loc_now[3:0], 2), 4'h0})
    else $error("two-byte read low byte from other conversion");
  AST_MIN_RST: assert property (@(posedge sys_clk) disable iff (reset)
    s_soft_write |=> s_reg.rw[`TMRM_SLOT_LMIN] == `TMRM_MIN_HI_RST
      && s_reg.rw[`TMRM_SLOT_LMIN + 5'd1] == `TMRM_MIN_LO_RST)
    else $error("minimum tracker not at top value");
  AST_MAX_RST: assert property (@(posedge sys_clk) disable iff (reset)
    s_soft_write |=> s_reg.rw[`TMRM_SLOT_RMAX] == 8'h00 && s_reg.rw[`TMRM_SLOT_RMAX + 5'd1] == 8'h00)
    else $error("maximum tracker not cleared");
  AST_RO_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
    bus_wr_valid && s_reg.phase == PH_WRITE && s_reg.idx == 2'd1 && !wr_hit[5]
      && s_reg.ptr != `TMRM_PTR_SOFT_RST && !loc_done && !rem_done |=> $stable(s_reg.rw))
    else $error("write to read-only pointer changed a register");
  AST_SPLIT_MAP: assert property (@(posedge sys_clk) disable iff (reset)
    bus_wr_valid && s_reg.phase == PH_WRITE && s_reg.idx == 2'd1 && s_reg.ptr == 8'h0b
      && !bus_start |=> s_reg.rw[`TMRM_SLOT_LUH] == $past(bus_wr_byte))
    else $error("limit write pointer not mapped");
  AST_ID_READ: assert property (@(posedge sys_clk) disable iff (reset)
    bus_rd_req && s_reg.phase == PH_READ && s_reg.idx == 2'd0 && s_reg.ptr == `TMRM_PTR_MAKER
      |=> bus_rd_byte == MAKER_CODE)
    else $error("maker code wrong");
  AST_SOFT_ALL: assert property (@(posedge sys_clk) disable iff (reset)
    s_soft_write |=> s_reg.rw == RW_RESET && lnk.loc_now == '0)
    else $error("software reset incomplete");

  // First byte of a read transaction
  sequence s_read_first;
    bus_rd_req && s_reg.phase == PH_READ && s_reg.idx == 2'd0;
  endsequence

  AST_LOC_HIGH: assert property (@(posedge sys_clk) disable iff (reset)
    s_read_first ##0 s_reg.ptr == `TMRM_PTR_LOC_HI |=> bus_rd_byte == $past(lnk.loc_hi))
    else $error("local high byte read wrong");
  AST_REM_HIGH: assert property (@(posedge sys_clk) disable iff (reset)
    s_read_first ##0 s_reg.ptr == `TMRM_PTR_REM_HI |=> bus_rd_byte == $past(lnk.rem_hi))
    else $error("remote high byte read wrong");
  AST_FRAC_ZERO: assert property (@(posedge sys_clk) disable iff (reset)
    s_read_first ##0 s_reg.ptr == `TMRM_PTR_LOC_LO |=> bus_rd_byte[3:0] == 4'h0)
    else $error("low byte read has bits below the fraction");
  AST_WO_READ: assert property (@(posedge sys_clk) disable iff (reset)
    s_read_first ##0 s_reg.ptr == `TMRM_PTR_SOFT_RST |=> bus_rd_byte == 8'h00)
    else $error("write-only pointer read back data");
  AST_PART_READ: assert property (@(posedge sys_clk) disable iff (reset)
    s_read_first ##0 s_reg.ptr == `TMRM_PTR_PART |=> bus_rd_byte == PART_CODE)
    else $error("part code wrong");
  // Bus writes to the local result pointers never reach the local result
  AST_RES_READONLY: assert property (@(posedge sys_clk) disable iff (reset)
    bus_wr_valid && s_reg.phase == PH_WRITE && s_reg.idx == 2'd1 && !loc_done && !rem_done
      && (s_reg.ptr == `TMRM_PTR_LOC_HI || s_reg.ptr == `TMRM_PTR_LOC_LO) |=> $stable(lnk.loc_now))
    else $error("bus write changed a result");
  AST_LIMIT_LOW: assert property (@(posedge sys_clk) disable iff (reset)
    bus_wr_valid && s_reg.phase == PH_WRITE && s_reg.idx == 2'd2 && s_reg.ptr == 8'h0b
      |=> s_reg.rw[`TMRM_SLOT_LUL] == ($past(bus_wr_byte) & 8'hf0))
    else $error("two-byte limit write low byte lost");
  AST_RATE_OUT: assert property (@(posedge sys_clk) disable iff (reset)
    bus_wr_valid && s_reg.phase == PH_WRITE && s_reg.idx == 2'd1 && s_reg.ptr == 8'h0a
      |=> rate_out == ($past(bus_wr_byte) & 8'h0f))
    else $error("rate write pointer not mapped");
endmodule // tmrm_regbank

// ===== sim/tmrm_host.sv
// Host model driving the byte-level register port
`timescale 1ns/1ps
module tmrm_host (
  // Clock
  input wire logic sys_clk,
  // Requests
  output logic bus_start,
  output logic bus_read,
  output logic bus_stop,
  output logic bus_wr_valid,
  output logic [7:0] bus_wr_byte,
  output logic bus_rd_req,
  // Answers
  input wire logic [7:0] bus_rd_byte,
  input wire logic bus_rd_valid
);
  logic [7:0] rq [0:3];

  initial begin
    bus_start = 1'b0;
    bus_read = 1'b0;
    bus_stop = 1'b0;
    bus_wr_valid = 1'b0;
    bus_wr_byte = 8'h00;
    bus_rd_req = 1'b0;
  end

  task automatic begin_txn(input logic rd);
    @(negedge sys_clk);
    bus_start = 1'b1;
    bus_read = rd;
    @(negedge sys_clk);
    bus_start = 1'b0;
  endtask

  task automatic end_txn();
    bus_stop = 1'b1;
    @(negedge sys_clk);
    bus_stop = 1'b0;
  endtask

  task automatic wr(input logic [7:0] p, input int n, input logic [7:0] d0, input logic [7:0] d1);
    logic [7:0] b [0:2];
    b[0] = p;
    b[1] = d0;
    b[2] = d1;
    begin_txn(1'b0);
    for (int i = 0; i <= n; i++) begin
      bus_wr_valid = 1'b1;
      bus_wr_byte = b[i];
      @(negedge sys_clk);
    end
    bus_wr_valid = 1'b0;
    // Released byte lane must not look stable
    bus_wr_byte = ~bus_wr_byte;
    end_txn();
  endtask

  // high byte first, low byte next
  task automatic rd(input int n);
    begin_txn(1'b1);
    bus_rd_req = 1'b1;
    // Answer pulse stands in the cycle after each request edge
    for (int j = 0; j < n; j++) begin
      @(negedge sys_clk);
      if (j == n - 1) begin
        bus_rd_req = 1'b0;
      end
      // Missing answer pulse poisons the byte
      rq[j] = bus_rd_valid ? bus_rd_byte : 8'hxx;
    end
    end_txn();
  endtask
endmodule // tmrm_host

// ===== sim/temp_monitor_register_map_tb.sv
// Self-checking bench for the temperature monitor register bank
`timescale 1ns/1ps
`include "tmrm_params.svh"
module temp_monitor_register_map_tb;
  localparam logic [8*`TMRM_NSLOT-1:0] RD_P = `TMRM_RD_PTRS;
  localparam logic [8*`TMRM_NSLOT-1:0] WR_P = `TMRM_WR_PTRS;
  localparam logic [8*`TMRM_NSLOT-1:0] RST_V = `TMRM_RW_RESET;
  localparam logic [8*`TMRM_NSLOT-1:0] MSK = `TMRM_RW_MASK;
  localparam logic [7:0] MAKER = 8'h77; // Arbitrary value
  localparam logic [7:0] PART = 8'h2d; // Arbitrary value
  logic sys_clk, reset, bus_start, bus_read, bus_stop, bus_wr_valid, bus_rd_req, bus_rd_valid;
  logic [7:0] bus_wr_byte, bus_rd_byte, status_flags, setup_out, rate_out, precision_out, correction_out;
  logic loc_done, rem_done;
  logic [11:0] loc_data, rem_data;
  int fail_count = 0;
  int comparisons = 0;

  tmrm_regbank #(.MAKER_CODE(MAKER), .PART_CODE(PART)) dut_u (.sys_clk(sys_clk), .reset(reset),
    .bus_start(bus_start), .bus_read(bus_read), .bus_stop(bus_stop), .bus_wr_valid(bus_wr_valid),
    .bus_wr_byte(bus_wr_byte), .bus_rd_req(bus_rd_req), .bus_rd_byte(bus_rd_byte), .bus_rd_valid(bus_rd_valid),
    .loc_done(loc_done), .loc_data(loc_data), .rem_done(rem_done), .rem_data(rem_data),
    .status_flags(status_flags), .setup_out(setup_out), .rate_out(rate_out),
    .precision_out(precision_out), .correction_out(correction_out));
  tmrm_host host_u (.sys_clk(sys_clk), .bus_start(bus_start), .bus_read(bus_read), .bus_stop(bus_stop),
    .bus_wr_valid(bus_wr_valid), .bus_wr_byte(bus_wr_byte), .bus_rd_req(bus_rd_req),
    .bus_rd_byte(bus_rd_byte), .bus_rd_valid(bus_rd_valid));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic do_reset();
    reset = 1'b1;
    repeat (3) @(negedge sys_clk);
    reset = 1'b0;
  endtask

  task automatic conv(input logic rem, input logic [11:0] v);
    @(negedge sys_clk);
    if (rem) begin
      rem_done = 1'b1;
      rem_data = v;
    end else begin
      loc_done = 1'b1;
      loc_data = v;
    end
    @(negedge sys_clk);
    loc_done = 1'b0;
    rem_done = 1'b0;
    // Result lanes only valid with the pulse
    loc_data = ~v;
    rem_data = ~v;
  endtask

  task automatic rd1(input logic [7:0] p, input logic [7:0] exp);
    host_u.wr(p, 0, 8'h00, 8'h00);
    host_u.rd(1);
    chk($sformatf("ptr %h", p), exp, host_u.rq[0]);
  endtask

  function automatic logic [7:0] exp_v(input int i);
    logic [7:0] m;
    m = MSK[8*i +: 8];
    return ((8'h5a ^ 8'(i)) & m) | (RST_V[8*i +: 8] & ~m);
  endfunction

  task automatic check_resets();
    for (int i = 0; i < `TMRM_NSLOT; i++) begin
      rd1(RD_P[8*i +: 8], RST_V[8*i +: 8]);
    end
    rd1(8'h00, 8'h00);
    rd1(8'h01, 8'h00);
    rd1(8'h10, 8'h00);
    rd1(8'h15, 8'h00);
    rd1(8'hff, PART);
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    close_out();
  end

  initial begin
    loc_done = 1'b0;
    rem_done = 1'b0;
    loc_data = 12'h000;
    rem_data = 12'h000;
    status_flags = 8'h00;
    do_reset();
    check_resets();
    $display("test reset_values done");
    for (int i = 0; i < `TMRM_NSLOT; i++) begin
      host_u.wr(WR_P[8*i +: 8], 1, 8'h5a ^ 8'(i), 8'h00);
      rd1(RD_P[8*i +: 8], exp_v(i));
    end
    chk("setup_out", exp_v(`TMRM_SLOT_SETUP), setup_out);
    chk("rate_out", exp_v(`TMRM_SLOT_RATE), rate_out);
    chk("precision_out", exp_v(`TMRM_SLOT_PREC), precision_out);
    chk("correction_out", exp_v(`TMRM_SLOT_CORR), correction_out);
    $display("test split_pointers done");
    host_u.wr(8'h00, 1, 8'h77, 8'h00);
    rd1(8'h00, 8'h00);
    host_u.wr(8'hfe, 1, 8'h00, 8'h00);
    rd1(8'hfe, MAKER);
    rd1(8'hfc, 8'h00);
    rd1(8'h0b, 8'h00);
    host_u.wr(8'h0b, 2, 8'h66, 8'h9f);
    host_u.wr(8'h05, 0, 8'h00, 8'h00);
    host_u.rd(2);
    chk("limit high", 8'h66, host_u.rq[0]);
    chk("limit low", 8'h90, host_u.rq[1]);
    $display("test access_kinds done");
    conv(1'b0, 12'hab7);
    host_u.wr(8'h00, 0, 8'h00, 8'h00);
    host_u.rd(2);
    chk("local pair high", 8'hab, host_u.rq[0]);
    chk("local pair low", 8'h70, host_u.rq[1]);
    host_u.rd(1);
    conv(1'b0, 12'h123);
    rd1(8'h15, 8'h70);
    host_u.rd(1);
    chk("local live low", 8'h30, host_u.rq[0]);
    rd1(8'h00, 8'h12);
    conv(1'b1, 12'h5c9);
    rd1(8'h01, 8'h5c);
    conv(1'b1, 12'h4e2);
    for (int k = 0; k < 2; k++) begin
      status_flags = 8'h81 << k;
      rd1(8'h02, 8'h81 << k);
    end
    rd1(8'h10, 8'h20);
    $display("test coherence done");
    do_reset();
    conv(1'b0, 12'h3f0);
    host_u.rd(1);
    chk("pointer after reset", 8'h3f, host_u.rq[0]);
    host_u.wr(8'h09, 1, 8'he4, 8'h00);
    chk("setup_out", 8'he4, setup_out);
    host_u.wr(8'hfc, 2, 8'h3c, 8'h00);
    chk("setup_out", 8'h00, setup_out);
    check_resets();
    $display("test restart done");
    close_out();
  end
endmodule // temp_monitor_register_map_tb
